// ==== hdl/cslt_core.sv ====
`timescale 1ns/1ps
module cslt_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chain_input_line,
    output logic chain_output_line,
    output logic chain_output_oe
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctl_q;
    logic [2:0] div_q;
    logic [4:0] ths_q, zh_q, oh_q;
    logic [7:0] per_q, rper_q;
    logic [7:0] d0_q, d1_q, d2_q;
    logic [3:0] ien_q;
    logic err_q, cres_q, empty_q, full_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    cslt_pkg::cslt_out_type out_q;

    // Link engine state
    typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} cslt_state_type;
    cslt_state_type st_q;
    logic [6:0] pre_q;
    logic [3:0] rdiv_q;
    logic [7:0] bit_period_count_q, reset_period_count_q;
    logic [4:0] hcnt_q, bit_q;
    logic [23:0] sh_q;
    logic in_q;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire en = ctl_q[cslt_pkg::CTL_ENABLE];
    wire tx_mode = ctl_q[cslt_pkg::CTL_DIRECTION];
    wire rx_en = ctl_q[cslt_pkg::CTL_RX_ENABLE];
    wire bypass = ctl_q[cslt_pkg::CTL_BYPASS];
    wire check = ctl_q[cslt_pkg::CTL_CHECK];
    wire access = psel && penable && !pready_q;
    wire wr = psel && penable && pready_q && pwrite; // Lands with ready
    wire wr_ctl = wr && paddr == cslt_pkg::OFS_CONTROL;
    wire wr_d0 = wr && paddr == cslt_pkg::OFS_DATA0;
    wire wr_d1 = wr && paddr == cslt_pkg::OFS_DATA1;
    wire wr_d2 = wr && paddr == cslt_pkg::OFS_DATA2;
    wire mapped = paddr <= cslt_pkg::OFS_EVENT && paddr[1:0] == 2'b00;
    wire din = en & chain_input_line;
    wire rise = din & ~in_q;
    wire fall = ~din & in_q;

    wire [7:0] pre_mask = 8'((9'h001 << div_q) - 9'h001);
    wire tick = en && ((8'(pre_q) & pre_mask) == pre_mask);
    // Reset timer tick is link tick / 16
    wire rtick = tick && rdiv_q == 4'(cslt_pkg::RESET_TICK_DIV - 1);

    wire trig_set = wr_ctl && pwdata[cslt_pkg::CTL_TRIGGER] && en;
    wire tx_start = trig_set && tx_mode && st_q == ST_IDLE;
    wire tx_bit = sh_q[23];
    // High phase length by bit value
    wire [4:0] hi_len = tx_bit ? oh_q : zh_q;
    wire tx_last = bit_q == 5'(cslt_pkg::FRAME_BITS - 1);
    // Period counter runs in transmit while a frame is active
    wire tx_bit_end = tick && st_q != ST_IDLE && bit_period_count_q <= 8'h01;
    wire tx_done = tx_mode && tx_bit_end && tx_last;
    // Receive path: counts only when receive is enabled
    wire rx_act = en && !tx_mode && rx_en;
    wire rx_last = bit_q == 5'(cslt_pkg::FRAME_BITS - 1);
    wire rx_one = hcnt_q >= ths_q;
    // Expiry counted only with check on
    wire expired = check && st_q != ST_IDLE && bit_period_count_q == 8'h00;
    wire rx_err = rx_act && expired && !err_q;
    // Last bit finished by its falling edge
    wire rx_full = rx_act && st_q == ST_HIGH && fall && rx_last;
    wire line_reset = en && !tx_mode && rtick && reset_period_count_q == 8'h01;

    // ------------------------------------------------------------
    // Control register update
    // ------------------------------------------------------------
    logic [7:0] ctl_d;
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d[cslt_pkg::CTL_ENABLE] = pwdata[cslt_pkg::CTL_ENABLE];
            ctl_d[cslt_pkg::CTL_CHECK] = pwdata[cslt_pkg::CTL_CHECK];
            ctl_d[cslt_pkg::CTL_RX_ENABLE] = pwdata[cslt_pkg::CTL_RX_ENABLE];
            ctl_d[cslt_pkg::CTL_RESERVED] = pwdata[cslt_pkg::CTL_RESERVED];
            ctl_d[cslt_pkg::CTL_BYPASS] = pwdata[cslt_pkg::CTL_BYPASS];
            if (!en) begin
                ctl_d[cslt_pkg::CTL_DIRECTION] =
                    pwdata[cslt_pkg::CTL_DIRECTION];
            end
            if (trig_set) ctl_d[cslt_pkg::CTL_TRIGGER] = 1'b1;
        end
        if (tx_done) ctl_d[cslt_pkg::CTL_TRIGGER] = 1'b0;
        if (rx_full) begin
            ctl_d[cslt_pkg::CTL_RX_ENABLE] = 1'b0;
            ctl_d[cslt_pkg::CTL_BYPASS] = 1'b1;
        end
        if (line_reset) begin
            ctl_d[cslt_pkg::CTL_RX_ENABLE] = 1'b1;
            ctl_d[cslt_pkg::CTL_BYPASS] = 1'b0;
        end
        if (!ctl_d[cslt_pkg::CTL_ENABLE]) ctl_d[cslt_pkg::CTL_TRIGGER] = 1'b0;
        ctl_d[7] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= cslt_pkg::RST_CONTROL;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // ------------------------------------------------------------
    // Timing and data registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= cslt_pkg::RST_DIVIDER;
            ths_q <= cslt_pkg::RST_THRESHOLD;
            zh_q <= cslt_pkg::RST_ZERO_HIGH;
            oh_q <= cslt_pkg::RST_ONE_HIGH;
            per_q <= cslt_pkg::RST_BIT_PERIOD;
            rper_q <= cslt_pkg::RST_RESET_PERIOD;
            ien_q <= 4'h0;
        end else if (wr) begin
            unique case (paddr)
                cslt_pkg::OFS_DIVIDER: div_q <= pwdata[2:0];
                cslt_pkg::OFS_THRESHOLD: ths_q <= pwdata[4:0];
                cslt_pkg::OFS_ZERO_HIGH: zh_q <= pwdata[4:0];
                cslt_pkg::OFS_ONE_HIGH: oh_q <= pwdata[4:0];
                cslt_pkg::OFS_BIT_PERIOD: per_q <= pwdata[7:0];
                cslt_pkg::OFS_RESET_PERIOD: rper_q <= pwdata[7:0];
                cslt_pkg::OFS_EVENT: ien_q <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // Data bytes: software writes, receive loads on full
    // Left as is on disable; software must not trust them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d0_q <= 8'h00;
            d1_q <= 8'h00;
            d2_q <= 8'h00;
        end else if (rx_full) begin
            {d0_q, d1_q, d2_q} <= {sh_q[22:0], rx_one};
        end else begin
            if (wr_d0) d0_q <= pwdata[7:0];
            if (wr_d1) d1_q <= pwdata[7:0];
            if (wr_d2) d2_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Status flags; disable and line reset clears win over events
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
            cres_q <= 1'b0;
            empty_q <= 1'b0;
            full_q <= 1'b0;
        end else if (!ctl_d[cslt_pkg::CTL_ENABLE]) begin
            err_q <= 1'b0;
            cres_q <= 1'b0;
            empty_q <= 1'b0;
            full_q <= 1'b0;
        end else if (line_reset) begin
            err_q <= 1'b0;
            full_q <= 1'b0;
            cres_q <= 1'b1;
        end else begin
            if (rx_err) err_q <= 1'b1;
            if (rx_full) full_q <= 1'b1;
            // Trigger clears empty; done sets it
            if (tx_done) empty_q <= 1'b1;
            else if (trig_set) empty_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Prescaler and reset timer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 7'h00;
            rdiv_q <= 4'h0;
            reset_period_count_q <= cslt_pkg::RST_RESET_PERIOD;
            in_q <= 1'b0;
        end else begin
            in_q <= din;
            pre_q <= (en && !tx_start) ? pre_q + 7'h01 : 7'h00;
            if (tick) rdiv_q <= rdiv_q + 4'h1;
            // Any line edge restarts the idle timer
            if (!en || tx_mode || rise || fall) begin
                reset_period_count_q <= rper_q;
            end else if (rtick && reset_period_count_q != 8'h00) begin
                reset_period_count_q <= reset_period_count_q - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit engine: shared by transmit and receive
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            bit_period_count_q <= 8'h00;
            hcnt_q <= 5'h00;
            bit_q <= 5'h00;
            sh_q <= 24'h00_0000;
        end else if (!en || line_reset) begin
            st_q <= ST_IDLE;
            bit_q <= 5'h00;
        end else if (tx_mode) begin
            if (tx_start) begin
                sh_q <= {d0_q, d1_q, d2_q};
                st_q <= ST_HIGH;
                bit_period_count_q <= per_q;
                hcnt_q <= 5'h00;
                bit_q <= 5'h00;
            end else if (tick && st_q != ST_IDLE) begin
                hcnt_q <= hcnt_q + 5'h01;
                bit_period_count_q <= bit_period_count_q - 8'h01;
                if (st_q == ST_HIGH && hcnt_q + 5'h01 >= hi_len)
                    st_q <= ST_LOW;
                if (tx_bit_end) begin
                    st_q <= tx_last ? ST_IDLE : ST_HIGH;
                    bit_period_count_q <= per_q;
                    hcnt_q <= 5'h00;
                    bit_q <= bit_q + 5'h01;
                    sh_q <= {sh_q[22:0], 1'b0};
                end
            end
        end else if (!rx_act || rx_err) begin
            st_q <= ST_IDLE;
            bit_q <= 5'h00;
        end else if (rise) begin
            // Each rising edge restarts bit period
            st_q <= ST_HIGH;
            bit_period_count_q <= per_q;
            hcnt_q <= {4'h0, tick}; // Rise cycle counts as high
        end else if (fall && st_q == ST_HIGH) begin
            // Bit judged at its falling edge
            st_q <= rx_last ? ST_IDLE : ST_LOW;
            sh_q <= {sh_q[22:0], rx_one};
            bit_q <= rx_last ? 5'h00 : bit_q + 5'h01;
        end else if (tick) begin
            if (st_q == ST_HIGH && hcnt_q != 5'h1F) hcnt_q <= hcnt_q + 5'h01;
            if (bit_period_count_q != 8'h00) bit_period_count_q <= bit_period_count_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Output line
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            out_q.oe <= ctl_d[cslt_pkg::CTL_ENABLE];
            if (tx_mode) begin
                out_q.line <= ctl_d[cslt_pkg::CTL_ENABLE] && st_q == ST_HIGH;
            end else begin
                out_q.line <= bypass & din;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            cslt_pkg::OFS_CONTROL: rd_d[7:0] = ctl_q;
            cslt_pkg::OFS_DIVIDER: rd_d[2:0] = div_q;
            cslt_pkg::OFS_THRESHOLD: rd_d[4:0] = ths_q;
            cslt_pkg::OFS_ZERO_HIGH: rd_d[4:0] = zh_q;
            cslt_pkg::OFS_ONE_HIGH: rd_d[4:0] = oh_q;
            cslt_pkg::OFS_BIT_PERIOD: rd_d[7:0] = per_q;
            cslt_pkg::OFS_RESET_PERIOD: rd_d[7:0] = rper_q;
            cslt_pkg::OFS_DATA0: rd_d[7:0] = d0_q;
            cslt_pkg::OFS_DATA1: rd_d[7:0] = d1_q;
            cslt_pkg::OFS_DATA2: rd_d[7:0] = d2_q;
            cslt_pkg::OFS_EVENT: rd_d[7:0] =
                {err_q, cres_q, empty_q, full_q, ien_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !mapped;
            prdata_q <= (access && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign chain_output_line = out_q.line;
    assign chain_output_oe = out_q.oe;

endmodule

// ==== hdl/cslt_pkg.sv ====
package cslt_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_DIVIDER = 8'h04;
    localparam logic [7:0] OFS_THRESHOLD = 8'h08;
    localparam logic [7:0] OFS_ZERO_HIGH = 8'h0C;
    localparam logic [7:0] OFS_ONE_HIGH = 8'h10;
    localparam logic [7:0] OFS_BIT_PERIOD = 8'h14;
    localparam logic [7:0] OFS_RESET_PERIOD = 8'h18;
    localparam logic [7:0] OFS_DATA0 = 8'h1C;
    localparam logic [7:0] OFS_DATA1 = 8'h20;
    localparam logic [7:0] OFS_DATA2 = 8'h24;
    localparam logic [7:0] OFS_EVENT = 8'h28;

    // ------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------
    localparam int CTL_ENABLE = 0;
    localparam int CTL_DIRECTION = 1;
    localparam int CTL_BYPASS = 2;
    localparam int CTL_TRIGGER = 3;
    localparam int CTL_RESERVED = 4;
    localparam int CTL_RX_ENABLE = 5;
    localparam int CTL_CHECK = 6;

    // ------------------------------------------------------------
    // Event register bit positions
    // ------------------------------------------------------------
    localparam int EVT_FULL = 4;
    localparam int EVT_EMPTY = 5;
    localparam int EVT_RESET = 6;
    localparam int EVT_ERROR = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h40;
    localparam logic [2:0] RST_DIVIDER = 3'h0;
    localparam logic [4:0] RST_THRESHOLD = 5'h07;
    localparam logic [4:0] RST_ZERO_HIGH = 5'h04;
    localparam logic [4:0] RST_ONE_HIGH = 5'h0A;
    localparam logic [7:0] RST_BIT_PERIOD = 8'h18;
    localparam logic [7:0] RST_RESET_PERIOD = 8'h80;

    // ------------------------------------------------------------
    // Timing and frame constants
    // ------------------------------------------------------------
    localparam int RESET_TICK_DIV = 16;
    localparam int FRAME_BITS = 24;
    localparam int PRESCALE_BITS = 7;

    // Link-facing signals of the block
    typedef struct packed {
        logic line;
        logic oe;
    } cslt_out_type;

endpackage

// ==== verification/cslt_bench.sv ====
`timescale 1ns/1ps
module cslt_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, din, dout, doe, er;
    int bad_count = 0;
    int comparisons = 0;

    // Clock, 10 ns period
    always #5 pclk = ~pclk;

    cslt_core dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chain_input_line(din),
        .chain_output_line(dout), .chain_output_oe(doe)
    );
    cslt_line_model m (
        .pclk(pclk), .drive_line(din), .sense_line(dout), .sense_oe(doe)
    );

    // ----
    // Report, compare and bus tasks
    // ----
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic to_fail;
        bad_count++;
        end_of_test();
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Setup, access, then hold until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1) begin
            @(posedge pclk);
            if (++n > 20) to_fail();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("register %h", a), {24'h00_0000, e}, rd);
    endtask

    // Poll events until all mask bits are seen
    task automatic wait_evt(input logic [7:0] mask);
        int n;
        n = 0;
        apb(1'b0, cslt_pkg::OFS_EVENT, 32'h0000_0000);
        while ((rd[7:0] & mask) !== mask) begin
            apb(1'b0, cslt_pkg::OFS_EVENT, 32'h0000_0000);
            if (++n > 300) to_fail();
        end
    endtask

    task automatic wait_bits(input int nb);
        int n;
        n = 0;
        while (m.got_bits < nb) begin
            @(posedge pclk);
            if (++n > 3000) to_fail();
        end
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        logic [7:0] rv [11];
        rv = '{8'h40, 8'h00, 8'h07, 8'h04, 8'h0A, 8'h18, 8'h80,
            8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 11; i++) rdchk(8'(i * 4), rv[i]);
        rdchk(8'h2C, 8'h00);
        chk("unmapped error", 32'h0000_0001, {31'h0, er});
        rdchk(8'h05, 8'h00);
        chk("misaligned error", 32'h0000_0001, {31'h0, er});
        wr(cslt_pkg::OFS_EVENT, 8'hFF);
        rdchk(cslt_pkg::OFS_EVENT, 8'h0F);
        wr(cslt_pkg::OFS_EVENT, 8'h00);
    endtask

    task automatic t_tx;
        wr(cslt_pkg::OFS_DATA0, 8'hA5);
        wr(cslt_pkg::OFS_DATA1, 8'h3C);
        wr(cslt_pkg::OFS_DATA2, 8'h0F);
        wr(cslt_pkg::OFS_CONTROL, 8'h4A);
        rdchk(cslt_pkg::OFS_CONTROL, 8'h42);
        wr(cslt_pkg::OFS_CONTROL, 8'h43);
        wr(cslt_pkg::OFS_CONTROL, 8'h4B);
        wait_bits(24);
        chk("tx word", 32'h00A5_3C0F, {8'h00, m.got_word});
        chk("tx bit shape", 32'h0000_0000, 32'(m.bad_bits));
        wait_evt(8'h20);
        chk("tx events", 32'h0000_0020, rd);
        rdchk(cslt_pkg::OFS_CONTROL, 8'h43);
        m.got_bits = 0;
        wr(cslt_pkg::OFS_CONTROL, 8'h49);
        rdchk(cslt_pkg::OFS_CONTROL, 8'h4B);
        rdchk(cslt_pkg::OFS_EVENT, 8'h00);
        wait_evt(8'h20);
        wr(cslt_pkg::OFS_CONTROL, 8'h43);
        wr(cslt_pkg::OFS_DIVIDER, 8'h01);
        m.scale = 2;
        m.got_bits = 0;
        wr(cslt_pkg::OFS_CONTROL, 8'h4B);
        wait_bits(24);
        chk("slow word", 32'h00A5_3C0F, {8'h00, m.got_word});
        chk("slow shape", 32'h0000_0000, 32'(m.bad_bits));
        wait_evt(8'h20);
        m.got_bits = 0;
        wr(cslt_pkg::OFS_CONTROL, 8'h4B);
        wait_bits(3);
        wr(cslt_pkg::OFS_CONTROL, 8'h42);
        rdchk(cslt_pkg::OFS_CONTROL, 8'h42);
        rdchk(cslt_pkg::OFS_EVENT, 8'h00);
        rdchk(cslt_pkg::OFS_DATA0, 8'hA5);
        chk("output enable", 32'h0000_0000, {31'h0, doe});
        wr(cslt_pkg::OFS_DIVIDER, 8'h00);
        m.scale = 1;
    endtask

    task automatic t_rx;
        wr(cslt_pkg::OFS_RESET_PERIOD, 8'h08);
        m.bad_bits = 0;
        wr(cslt_pkg::OFS_CONTROL, 8'h61);
        m.send(24'hC3_5A96, 24);
        wait_evt(8'h10);
        chk("rx events", 32'h0000_0010, rd);
        rdchk(cslt_pkg::OFS_CONTROL, 8'h45);
        rdchk(cslt_pkg::OFS_DATA0, 8'hC3);
        rdchk(cslt_pkg::OFS_DATA1, 8'h5A);
        rdchk(cslt_pkg::OFS_DATA2, 8'h96);
        m.got_bits = 0;
        m.send(24'h12_3456, 24);
        chk("passed word", 32'h0012_3456, {8'h00, m.got_word});
        chk("passed shape", 32'h0000_0000, 32'(m.bad_bits));
        wait_evt(8'h40);
        chk("line reset events", 32'h0000_0040, rd);
        rdchk(cslt_pkg::OFS_CONTROL, 8'h61);
    endtask

    task automatic t_err;
        m.send(24'h80_0000, 1);
        wait_evt(8'h80);
        chk("error events", 32'h0000_00C0, rd);
        wr(cslt_pkg::OFS_CONTROL, 8'h20);
        rdchk(cslt_pkg::OFS_EVENT, 8'h00);
        chk("output enable", 32'h0000_0000, {31'h0, doe});
        wr(cslt_pkg::OFS_CONTROL, 8'h21);
        m.send(24'h80_0000, 1);
        repeat (60) @(posedge pclk);
        apb(1'b0, cslt_pkg::OFS_EVENT, 32'h0000_0000);
        chk("unchecked error", 32'h0000_0000, rd & 32'h0000_0080);
        wr(cslt_pkg::OFS_CONTROL, 8'h20);
    endtask

    // Reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_err();
        end_of_test();
    end
endmodule

// ==== verification/cslt_line_model.sv ====
`timescale 1ns/1ps
module cslt_line_model (
    input wire logic pclk,
    output logic drive_line,
    input wire logic sense_line,
    input wire logic sense_oe
);
    // Bit shape in link ticks; scale is pclk cycles per tick
    int hi0 = 4;
    int hi1 = 10;
    int per = 24;
    int scale = 1;
    int run = 0;
    int hi_run = 0;
    int got_bits = 0;
    int bad_bits = 0;
    logic [23:0] got_word = 24'h00_0000;
    logic prev = 1'b0;

    // Upstream idles low, the chain's reset level
    initial drive_line = 1'b0;

    // one way, high then low, msb of byte 0 first
    task automatic send(input logic [23:0] w, input int n);
        int h;
        for (int i = 0; i < n; i++) begin
            h = w[23 - i] ? hi1 : hi0;
            @(posedge pclk);
            drive_line <= 1'b1;
            repeat (h * scale) @(posedge pclk);
            drive_line <= 1'b0;
            repeat ((per - h) * scale - 1) @(posedge pclk);
        end
    endtask

    // Decoder downstream; a floating line is not decoded
    always @(posedge pclk) begin
        if (sense_oe !== 1'b1) begin
            prev = 1'b0;
            run = 0;
        end else if (sense_line !== prev) begin
            if (sense_line === 1'b0) begin
                got_word = {got_word[22:0], run >= (hi0 + hi1) * scale / 2};
                if (run != (got_word[0] ? hi1 : hi0) * scale) bad_bits++;
                got_bits++;
                hi_run = run;
            end else if (got_bits > 0 && got_bits < 24
                && hi_run + run != per * scale) begin
                bad_bits++;
            end
            prev = sense_line;
            run = 1;
        end else begin
            run++;
        end
    end
endmodule

// ==== verification/cslt_sva.sv ====
`timescale 1ns/1ps
module cslt_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chain_input_line,
    input wire logic chain_output_line,
    input wire logic chain_output_oe
);
    // ----
    // Software view of the control register
    // ----
    logic wr_ctl, rd_ctl, rd_evt, unmap, en_q, dir_q, nochk_q;

    // Decodes; writes seen at the edge the slave takes them
    assign wr_ctl = psel && penable && pready && pwrite
        && paddr == cslt_pkg::OFS_CONTROL;
    assign rd_ctl = pready && !pwrite && paddr == cslt_pkg::OFS_CONTROL;
    assign rd_evt = pready && !pwrite && paddr == cslt_pkg::OFS_EVENT;
    assign unmap = paddr[1:0] != 2'b00 || paddr > cslt_pkg::OFS_EVENT;

    // Shadow; direction only follows while off, check-off needs disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            dir_q <= 1'b0;
            nochk_q <= 1'b0;
        end else if (wr_ctl) begin
            en_q <= pwdata[0];
            dir_q <= en_q ? dir_q : pwdata[1];
            nochk_q <= !pwdata[6] && (nochk_q || !pwdata[0]);
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero while idle");
    slverr_map_a: assert property (pready |-> pslverr == unmap)
        else $error("error response does not match address map");
    off_float_a: assert property (
        !en_q && !$past(en_q, 3) |-> !chain_output_oe)
        else $error("output driven while disabled");
    on_drive_a: assert property (
        en_q && $past(en_q, 3) |-> chain_output_oe)
        else $error("output not driven while enabled");
    dir_hold_a: assert property (
        rd_ctl |-> prdata[cslt_pkg::CTL_DIRECTION] == dir_q)
        else $error("direction changed while enabled");
    trig_off_a: assert property (
        rd_ctl && !en_q |-> !prdata[cslt_pkg::CTL_TRIGGER])
        else $error("trigger set while disabled");
    no_check_a: assert property (
        rd_evt && nochk_q |-> !prdata[cslt_pkg::EVT_ERROR])
        else $error("bit error with checking off");
    flags_off_a: assert property (
        rd_evt && !en_q |-> prdata[7:4] == 4'h0)
        else $error("event flags kept while disabled");

    // Main scenarios reached
    cover property (rd_evt && prdata[cslt_pkg::EVT_FULL]);
    cover property (rd_evt && prdata[cslt_pkg::EVT_ERROR]);
    cover property (pready && pslverr);
    cover property ($rose(chain_output_oe));
endmodule

bind cslt_core cslt_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .chain_input_line(chain_input_line),
    .chain_output_line(chain_output_line),
    .chain_output_oe(chain_output_oe)
);
